// ==== rtl/dbp_probe.sv ====
// Purpose: probe end, APB registers, scan sequencer, pin port
// Assumes: pclk at 10 MHz; link clock derived here by divider
// Notes:   pin inputs are synchronised before any use
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dbp_defs.svh"
module dbp_probe (
	input  wire logic        pclk,     // Bus clock
	input  wire logic        presetn,  // Async reset, low
	input  wire logic [7:0]  paddr,    // Byte address
	input  wire logic        psel,     // Slave select
	input  wire logic        penable,  // Access phase
	input  wire logic        pwrite,   // Write when high
	input  wire logic [31:0] pwdata,   // Write data
	output logic      [31:0] prdata,   // Read data
	output logic             pready,   // Always ready
	output logic             pslverr,  // Unmapped address
	dbp_link_if.probe        link      // Test link and pins
);
	import dbp_pkg::*;

	dbp_state_t state;
	logic       scan_en;
	logic       serial_en;
	logic       port_req;
	logic       two_wire;
	dbp_fmt_t   fmt;
	logic       port_on;
	logic       refused;
	logic [2:0] pin_dir;
	logic [2:0] pin_val;
	logic [7:0] tdi_sr;
	logic [7:0] tms_sr;
	logic [7:0] cap;
	logic [2:0] bits_left;
	logic [1:0] slot;
	logic [3:0] cnt;
	logic       tck_r;
	logic       busy;
	logic [2:0] gp_in;
	logic       tdo_s;
	logic       tms_s;
	logic       wr_acc;
	logic       start;
	logic       last_slot;

	// ============================================================
	// Address decode shared by write strobe and error answer
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == `DBP_OFF_CTRL) || (a == `DBP_OFF_CMD) ||
			(a == `DBP_OFF_STAT) || (a == `DBP_OFF_PINS);
	endfunction : mapped

	// Access completes in the first access cycle
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped(paddr);
	assign wr_acc  = psel && penable && pwrite && mapped(paddr);
	// A command while busy or with scan off is dropped
	assign start   = wr_acc && paddr == `DBP_OFF_CMD && !busy && scan_en;
	assign busy    = (state != DBP_IDLE);
	assign last_slot = !two_wire || slot == 2'h2;

	// ============================================================
	// Pin inputs cross into pclk
	dbp_sync u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({link.gpio, link.tdo, link.tms}),
		.q     ({gp_in, tdo_s, tms_s})
	);

	// ============================================================
	// Control register; port enable is checked against scan and
	// serial in the same write, so a bad request never opens it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_en   <= 1'(`DBP_CTRL_RST >> `DBP_CTRL_SCAN);
			serial_en <= 1'b0;
			port_req  <= 1'b0;
			two_wire  <= 1'b0;
			fmt       <= DBP_JSCAN0;
			port_on   <= 1'b0;
		end else if (wr_acc && paddr == `DBP_OFF_CTRL) begin
			scan_en   <= pwdata[`DBP_CTRL_SCAN];
			serial_en <= pwdata[`DBP_CTRL_SERIAL];
			port_req  <= pwdata[`DBP_CTRL_PORT];
			two_wire  <= pwdata[`DBP_CTRL_TWOWIRE];
			fmt       <= dbp_fmt_t'(pwdata[`DBP_CTRL_FMT_LO +: 4]);
			port_on   <= pwdata[`DBP_CTRL_PORT] &&
				!pwdata[`DBP_CTRL_SCAN] && !pwdata[`DBP_CTRL_SERIAL];
		end
	end

	// Refused flag: a new refusal wins over a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refused <= 1'b0;
		end else if (wr_acc && paddr == `DBP_OFF_CTRL &&
			pwdata[`DBP_CTRL_PORT] &&
			(pwdata[`DBP_CTRL_SCAN] || pwdata[`DBP_CTRL_SERIAL])) begin
			refused <= 1'b1;
		end else if (wr_acc && paddr == `DBP_OFF_STAT &&
			pwdata[`DBP_STAT_REFUSED]) begin
			refused <= 1'b0;
		end
	end

	// ============================================================
	// Pin direction and value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_dir <= `DBP_PINS_RST;
			pin_val <= `DBP_PINS_RST;
		end else if (wr_acc && paddr == `DBP_OFF_PINS) begin
			pin_dir <= pwdata[2:0];
			pin_val <= pwdata[`DBP_PINS_OUT_LO +: 3];
		end
	end

	// A pin drives only with the port on and set as output
	assign link.gp_o    = pin_val;
	assign link.gp_oe_n = ~(pin_dir & {3{port_on}});

	// ============================================================
	// Read data is registered in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			unique case (paddr)
				`DBP_OFF_CTRL: prdata <= {24'h000000, fmt, two_wire,
					port_req, serial_en, scan_en};
				`DBP_OFF_STAT: prdata <= {16'h0000, cap, 5'h00,
					refused, port_on, busy};
				`DBP_OFF_PINS: prdata <= {21'h000000, gp_in, 1'b0,
					pin_val, 1'b0, pin_dir};
				default:       prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ============================================================
	// Scan sequencer; each slot is setup, clock high, clock low,
	// then a settle wait that covers the input synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= DBP_IDLE;
			cnt       <= 4'h0;
			slot      <= 2'h0;
			bits_left <= 3'h0;
			tck_r     <= 1'b0;
		end else begin
			unique case (state)
				DBP_IDLE: begin
					tck_r <= 1'b0;
					if (start) begin
						bits_left <= pwdata[18:16];
						slot      <= 2'h0;
						state     <= DBP_SETUP;
					end
				end
				DBP_SETUP: begin
					cnt   <= 4'(`DBP_TCK_HIGH_CYC - 1);
					tck_r <= 1'b1;
					state <= DBP_RISE;
				end
				DBP_RISE: begin
					if (cnt == 4'h0) begin
						tck_r <= 1'b0;
						cnt   <= 4'(`DBP_SETTLE_CYC - 1);
						state <= DBP_FALL;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				DBP_FALL: begin
					state <= DBP_WAIT;
				end
				DBP_WAIT: begin
					if (cnt != 4'h0) begin
						cnt <= cnt - 4'h1;
					end else if (!last_slot) begin
						slot  <= slot + 2'h1;
						state <= DBP_SETUP;
					end else begin
						slot <= 2'h0;
						if (bits_left == 3'h0) begin
							state <= DBP_IDLE;
						end else begin
							bits_left <= bits_left - 3'h1;
							state     <= DBP_SETUP;
						end
					end
				end
			endcase
		end
	end

	// ============================================================
	// Shift data; ones fill in so the select line idles high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdi_sr <= 8'hFF;
			tms_sr <= 8'hFF;
		end else if (start) begin
			tdi_sr <= pwdata[7:0];
			tms_sr <= pwdata[15:8];
		end else if (state == DBP_WAIT && cnt == 4'h0 && last_slot) begin
			tdi_sr <= {1'b1, tdi_sr[7:1]};
			tms_sr <= {1'b1, tms_sr[7:1]};
		end
	end

	// ============================================================
	// Capture. The two-wire reply is released at the fall of its
	// own slot, before the synchroniser could deliver it at slot
	// end, so it is taken while the reply slot is still in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap <= 8'h00;
		end else if (two_wire && state == DBP_SETUP &&
			slot == 2'h2) begin
			cap <= {tms_s, cap[7:1]};
		end else if (!two_wire && state == DBP_WAIT && cnt == 4'h0) begin
			cap <= {tdo_s, cap[7:1]};
		end
	end

	// ============================================================
	// Link drives; lines released when scan is off, and in two-wire
	// mode the select line is freed for the target reply slot
	assign link.tck_o    = tck_r;
	assign link.tck_oe_n = !scan_en;
	assign link.tdi_o    = tdi_sr[0];
	assign link.tdi_oe_n = !scan_en || two_wire;
	assign link.tms_o    = (two_wire && slot == 2'h0) ? tdi_sr[0] : tms_sr[0];
	assign link.tms_oe_n = !scan_en || (two_wire && (slot == 2'h2 ||
		(slot == 2'h1 && (state == DBP_FALL || state == DBP_WAIT))));
endmodule : dbp_probe
`default_nettype wire

// ==== rtl/dbp_defs.svh ====
// Purpose: constants of the debug probe scan and pin port
// Assumes: included by bare name from the probe, sync and target files
// Notes:   offsets are byte addresses on the APB side
`ifndef DBP_DEFS_SVH
`define DBP_DEFS_SVH

// ============================================================
// Register offsets
`define DBP_OFF_CTRL      8'h00
`define DBP_OFF_CMD       8'h04
`define DBP_OFF_STAT      8'h08
`define DBP_OFF_PINS      8'h0C

// ============================================================
// Field positions
`define DBP_CTRL_SCAN     0
`define DBP_CTRL_SERIAL   1
`define DBP_CTRL_PORT     2
`define DBP_CTRL_TWOWIRE  3
`define DBP_CTRL_FMT_LO   4
`define DBP_STAT_BUSY     0
`define DBP_STAT_PORT     1
`define DBP_STAT_REFUSED  2
`define DBP_PINS_OUT_LO   4
`define DBP_PINS_IN_LO    8

// ============================================================
// Reset values
`define DBP_CTRL_RST      8'h00
`define DBP_PINS_RST      3'h0

// ============================================================
// Timing
`define DBP_PCLK_NS       100
`define DBP_TCK_HIGH_NS   100
`define DBP_TCK_HIGH_CYC  ((`DBP_TCK_HIGH_NS + `DBP_PCLK_NS - 1) / `DBP_PCLK_NS)
`define DBP_SETTLE_CYC    2
`define DBP_SYNC_W        5

`endif

// ==== rtl/dbp_pkg.sv ====
// Purpose: types shared by the probe and target ends
// Assumes: nothing
// Notes:   format codes carried in the control register
`default_nettype none
package dbp_pkg;

	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		DBP_IDLE  = 5'b00001,
		DBP_SETUP = 5'b00010,
		DBP_RISE  = 5'b00100,
		DBP_FALL  = 5'b01000,
		DBP_WAIT  = 5'b10000
	} dbp_state_t;

	// Scan format codes
	typedef enum logic [3:0] {
		DBP_JSCAN0 = 4'h0, DBP_JSCAN1 = 4'h1, DBP_JSCAN2 = 4'h2,
		DBP_JSCAN3 = 4'h3, DBP_MSCAN  = 4'h4,
		DBP_OSCAN0 = 4'h8, DBP_OSCAN1 = 4'h9, DBP_OSCAN2 = 4'hA,
		DBP_OSCAN3 = 4'hB, DBP_OSCAN4 = 4'hC, DBP_OSCAN5 = 4'hD,
		DBP_OSCAN6 = 4'hE, DBP_OSCAN7 = 4'hF
	} dbp_fmt_t;

endpackage : dbp_pkg
`default_nettype wire

// ==== rtl/dbp_link_if.sv ====
// Purpose: test link and pin wires between probe and target
// Assumes: each party gives output and active-low enable
// Notes:   undriven lines resolve high, as the pull-ups do
`timescale 1ns/1ps
`default_nettype none
interface dbp_link_if;
	logic       tck_o;       // Probe clock drive
	logic       tck_oe_n;    // Probe clock enable, low drives
	logic       tms_o;       // Probe select or select/data
	logic       tms_oe_n;    // Probe select enable
	logic       tdi_o;       // Probe data to target
	logic       tdi_oe_n;    // Probe data enable
	logic [2:0] gp_o;        // Probe pin values
	logic [2:0] gp_oe_n;     // Probe pin enables
	logic       tdo_o;       // Target data to probe
	logic       tdo_oe_n;    // Target data enable
	logic       bidi_o;      // Target select/data reply
	logic       bidi_oe_n;   // Target select/data enable
	logic [1:0] tg_o;        // Target pin values
	logic [1:0] tg_oe_n;     // Target pin enables
	logic       tck;         // Resolved clock line
	logic       tms;         // Resolved select line
	logic       tdi;         // Resolved data-in line
	logic       tdo;         // Resolved data-out line
	logic [2:0] gpio;        // Resolved pins

	// Wire levels; an undriven line reads one
	assign tck = !tck_oe_n ? tck_o : 1'b1;
	assign tms = !tms_oe_n ? tms_o : (!bidi_oe_n ? bidi_o : 1'b1);
	assign tdi = !tdi_oe_n ? tdi_o : 1'b1;
	assign tdo = !tdo_oe_n ? tdo_o : 1'b1;
	assign gpio[0] = !gp_oe_n[0] ? gp_o[0] : (!tg_oe_n[0] ? tg_o[0] : 1'b1);
	assign gpio[1] = !gp_oe_n[1] ? gp_o[1] : (!tg_oe_n[1] ? tg_o[1] : 1'b1);
	assign gpio[2] = !gp_oe_n[2] ? gp_o[2] : 1'b1;

	modport probe (output tck_o, tck_oe_n, tms_o, tms_oe_n, tdi_o, tdi_oe_n,
		gp_o, gp_oe_n, input tms, tdo, gpio);
	modport target (output tdo_o, tdo_oe_n, bidi_o, bidi_oe_n, tg_o, tg_oe_n,
		input tck, tms, tdi, gpio);
endinterface : dbp_link_if
`default_nettype wire

// ==== rtl/dbp_sync.sv ====
// Purpose: two-flop synchroniser for probe pin inputs
// Assumes: inputs are levels from outside the pclk domain
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
`include "dbp_defs.svh"
module dbp_sync (
	input  wire logic                   clk,    // Sampling clock
	input  wire logic                   rst_n,  // Async reset, low
	input  wire logic [`DBP_SYNC_W-1:0] d,      // Async levels
	output logic      [`DBP_SYNC_W-1:0] q       // Synchronised levels
);
	logic [`DBP_SYNC_W-1:0] meta;

	// Two stages; reset to the pulled-up idle level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= {`DBP_SYNC_W{1'b1}};
			q    <= {`DBP_SYNC_W{1'b1}};
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : dbp_sync
`default_nettype wire

// ==== rtl/dbp_target.sv ====
// Purpose: target end, a scan shift stage on the link clock
// Assumes: two_wire is static while the link clock runs
// Notes:   slot counter only advances on link clock edges
`timescale 1ns/1ps
`default_nettype none
`include "dbp_defs.svh"
module dbp_target (
	input  wire logic       rst_n,                    // Async reset, low
	input  wire logic       two_wire,                 // Two-wire mode
	input  wire logic [1:0] gp_drv_en,                // Drive pins 0..1
	input  wire logic [1:0] gp_drv_val,               // Values for pins
	output logic      [7:0] scan_data,                // Shift stage
	output logic            processor_system_reset_n, // Core reset, low
	output logic      [2:0] gpio_seen,                // Pin levels
	dbp_link_if.target      link                      // Test link
);
	import dbp_pkg::*;

	logic [1:0] slot;
	logic       tdi_hold;
	logic       tdo_r;
	logic       reply_oe_n;

	// ============================================================
	// Capture on rising clock
	// Two-wire packet: slot 0 data, slot 1 select, slot 2 reply
	always_ff @(posedge link.tck or negedge rst_n) begin
		if (!rst_n) begin
			scan_data <= 8'h00;
			slot      <= 2'h0;
			tdi_hold  <= 1'b1;
		end else if (two_wire) begin
			slot <= (slot == 2'h2) ? 2'h0 : slot + 2'h1;
			if (slot == 2'h0)
				tdi_hold <= link.tms;
			if (slot == 2'h1 && !link.tms)
				scan_data <= {tdi_hold, scan_data[7:1]};
		end else if (!link.tms) begin
			scan_data <= {link.tdi, scan_data[7:1]};
		end
	end

	// ============================================================
	// Launch on falling clock so the probe sees settled data
	always_ff @(negedge link.tck or negedge rst_n) begin
		if (!rst_n) begin
			tdo_r      <= 1'b1;
			reply_oe_n <= 1'b1;
		end else begin
			tdo_r      <= scan_data[0];
			reply_oe_n <= !(two_wire && slot == 2'h2);
		end
	end

	// ============================================================
	// Pin drives
	assign link.tdo_o     = tdo_r;
	assign link.tdo_oe_n  = two_wire;
	assign link.bidi_o    = tdo_r;
	assign link.bidi_oe_n = reply_oe_n;
	assign link.tg_o      = gp_drv_val;
	assign link.tg_oe_n   = ~gp_drv_en;

	// Third pin is the processor reset input
	assign processor_system_reset_n = link.gpio[2];
	assign gpio_seen                = link.gpio;
endmodule : dbp_target
`default_nettype wire

// ==== testbench/dbp_link_assertions.sv ====
// Purpose: link and pin checks between probe and target
// Assumes: the link clock is derived from pclk by the probe
// Notes:   one domain, so default clocking is used
`timescale 1ns/1ps
`default_nettype none
module dbp_link_assertions (
	input wire logic       pclk,      // Bus clock
	input wire logic       presetn,   // Async reset, low
	input wire logic       tck_o,     // Probe clock drive
	input wire logic       tck_oe_n,  // Probe clock enable
	input wire logic       tms_o,     // Probe select drive
	input wire logic       tms_oe_n,  // Probe select enable
	input wire logic       tdi_o,     // Probe data drive
	input wire logic       tdi_oe_n,  // Probe data enable
	input wire logic [2:0] gp_o,      // Probe pin values
	input wire logic [2:0] gp_oe_n,   // Probe pin enables
	input wire logic       tdo_oe_n,  // Target data enable
	input wire logic       bidi_oe_n, // Target reply enable
	input wire logic       tck,       // Resolved clock
	input wire logic       tms,       // Resolved select
	input wire logic       tdi,       // Resolved data in
	input wire logic       tdo,       // Resolved data out
	input wire logic [2:0] gpio       // Resolved pins
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ============================================================
	// Slot shape: low through fall, two settle cycles and setup
	sequence s_slot_low;
		(!tck_o) [*4];
	endsequence
	// Scan held on long enough for any register skew to settle
	sequence s_scan_held;
		(!tck_oe_n) [*3];
	endsequence

	chk_pull_clock: assert property (tck_oe_n |-> tck && tdi)
		else $error("released clock line not high");
	chk_pull_select: assert property (
		((tms_oe_n && bidi_oe_n) |-> tms) and (tdo_oe_n |-> tdo))
		else $error("released select or data line not high");
	chk_reset_idle: assert property ($rose(presetn) |->
		&gp_oe_n && tck_oe_n && tms_oe_n && tdi_oe_n)
		else $error("driver enabled after reset");
	chk_tck_pulse: assert property ($rose(tck_o) |=> $fell(tck_o))
		else $error("link clock high not one cycle");
	chk_slot_low: assert property ($fell(tck_o) |-> s_slot_low)
		else $error("link clock low phase too short");
	chk_lines_stable: assert property (tck_o |->
		$stable(tms_o) && $stable(tdi_o))
		else $error("select or data moved while clock high");
	chk_port_excl: assert property (s_scan_held |-> &gp_oe_n)
		else $error("pin driven while scan enabled");
	chk_pin_value: assert property (
		(gpio | gp_oe_n) == (gp_o | gp_oe_n))
		else $error("driven pin does not show its value");
endmodule : dbp_link_assertions
`default_nettype wire

// ==== testbench/debug_probe_scan_and_gpio_port_tb.sv ====
// Purpose: self-checking bench for probe and target ends
// Assumes: probe makes the link clock, target on far side
// Notes:   registers reached over APB, random with fixed seed
`timescale 1ns/1ps
`default_nettype none
module debug_probe_scan_and_gpio_port_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        two_wire = 1'b0;
	logic [1:0]  gp_drv_en = 2'h0;
	logic [1:0]  gp_drv_val = 2'h0;
	logic [7:0]  scan_data;
	logic        processor_system_reset_n;
	logic [2:0]  gpio_seen;
	logic [31:0] rdv;
	logic        err;
	int          fail_count = 0;
	int          compares = 0;

	dbp_link_if dbp_link_if_i ();
	dbp_probe dbp_probe_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(dbp_link_if_i.probe));
	dbp_target dbp_target_i (.rst_n(presetn), .two_wire(two_wire),
		.gp_drv_en(gp_drv_en), .gp_drv_val(gp_drv_val),
		.scan_data(scan_data), .gpio_seen(gpio_seen),
		.processor_system_reset_n(processor_system_reset_n),
		.link(dbp_link_if_i.target));
	dbp_link_assertions dbp_link_assertions_i (.pclk(pclk),
		.presetn(presetn), .tck_o(dbp_link_if_i.tck_o),
		.tck_oe_n(dbp_link_if_i.tck_oe_n), .tms_o(dbp_link_if_i.tms_o),
		.tms_oe_n(dbp_link_if_i.tms_oe_n), .tdi_o(dbp_link_if_i.tdi_o),
		.tdi_oe_n(dbp_link_if_i.tdi_oe_n), .gp_o(dbp_link_if_i.gp_o),
		.gp_oe_n(dbp_link_if_i.gp_oe_n), .tdo_oe_n(dbp_link_if_i.tdo_oe_n),
		.bidi_oe_n(dbp_link_if_i.bidi_oe_n), .tck(dbp_link_if_i.tck),
		.tms(dbp_link_if_i.tms), .tdi(dbp_link_if_i.tdi),
		.tdo(dbp_link_if_i.tdo), .gpio(dbp_link_if_i.gpio));

	// ============================================================
	// Clock, 100 ns period
	initial begin
		forever #50 pclk = ~pclk;
	end

	// ============================================================
	// Helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// One APB transfer; idle edge after it so strobes never re-assert
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			fail_count++;
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Poll status until the sequencer is idle, bounded
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			apb(1'b0, 8'h08, 32'h0);
			n++;
		end while (rdv[0] !== 1'b0 && n < 100);
		if (n >= 100)
			fail_count++;
	endtask : wait_idle

	task automatic tally_and_finish;
		$display("compares %0d, fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	// Pin level: probe first, then target, else pull-up
	function automatic logic [2:0] exp_pins(input logic on,
		input logic [2:0] dir, val, input logic [1:0] ten, tv);
		logic [2:0] p;
		logic [2:0] te;
		logic [2:0] tx;
		te = {1'b0, ten};
		tx = {1'b0, tv};
		for (int i = 0; i < 3; i++)
			p[i] = (on && dir[i]) ? val[i] : (te[i] ? tx[i] : 1'b1);
		return p;
	endfunction : exp_pins

	// Target stage and probe capture after eight bits
	function automatic logic [15:0] scan_model(input logic [7:0] old, dat, sel);
		logic [7:0] s;
		logic [7:0] c;
		s = old;
		c = 8'h00;
		for (int k = 0; k < 8; k++) begin
			if (!sel[k])
				s = {dat[k], s[7:1]};
			c = {s[0], c[7:1]};
		end
		return {s, c};
	endfunction : scan_model

	// Hang guard, far beyond the eleven hundred or so cycles needed
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		tally_and_finish;
	end

	// ============================================================
	// Main sequence
	initial begin
		logic [2:0]  dir;
		logic [2:0]  val;
		logic [2:0]  e;
		logic [7:0]  dat;
		logic [7:0]  sel;
		logic [7:0]  sd;
		logic [15:0] m;
		void'($urandom(32'h2bda));
		sd = 8'h00;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(32'(dbp_link_if_i.gp_oe_n), 32'h7);
		apb(1'b0, 8'h00, 32'h0);
		check(rdv, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		check(rdv, 32'h700);
		apb(1'b1, 8'h10, 32'hFFFF_FFFF);
		apb(1'b0, 8'h10, 32'h0);
		check({rdv[30:0], err}, 32'h1);
		// Pins driven, read back, then released by port off
		for (int i = 0; i < 8; i++) begin
			dir = (i == 0) ? 3'h7 : 3'($urandom);
			val = 3'($urandom);
			gp_drv_en <= 2'($urandom);
			gp_drv_val <= 2'($urandom);
			apb(1'b1, 8'h0C, {25'h0, val, 1'b0, dir});
			apb(1'b1, 8'h00, 32'h4);
			repeat (4) @(posedge pclk);
			e = exp_pins(1'b1, dir, val, gp_drv_en, gp_drv_val);
			check(32'(dbp_link_if_i.gpio), 32'(e));
			check(32'(processor_system_reset_n), 32'(e[2]));
			apb(1'b0, 8'h0C, 32'h0);
			check(rdv, {21'h0, e, 1'b0, val, 1'b0, dir});
			apb(1'b0, 8'h08, 32'h0);
			check(rdv & 32'h6, 32'h2);
			apb(1'b1, 8'h00, 32'h0);
			repeat (2) @(posedge pclk);
			e = exp_pins(1'b0, dir, val, gp_drv_en, gp_drv_val);
			check(32'(gpio_seen), 32'(e));
		end
		// Port request with scan or serial on is refused
		for (int k = 1; k < 4; k++) begin
			apb(1'b1, 8'h0C, 32'h7);
			apb(1'b1, 8'h00, 32'h4 | k);
			repeat (4) @(posedge pclk);
			check(32'(dbp_link_if_i.gp_oe_n), 32'h7);
			apb(1'b0, 8'h08, 32'h0);
			check(rdv & 32'h6, 32'h4);
			apb(1'b1, 8'h08, 32'h4);
			apb(1'b0, 8'h08, 32'h0);
			check(rdv & 32'h4, 32'h0);
			apb(1'b1, 8'h00, 32'h0);
		end
		// Every scan format is accepted and read back
		for (int f = 0; f < 16; f++) begin
			if (f inside {[5:7]})
				continue;
			apb(1'b1, 8'h00, 32'h1 | (f << 4));
			apb(1'b0, 8'h00, 32'h0);
			check(rdv, 32'h1 | (f << 4));
		end
		// Eight-bit shifts, 4-wire then 2-wire, second command ignored
		for (int tw = 0; tw < 2; tw++) begin
			two_wire <= tw[0];
			apb(1'b1, 8'h00, 32'h1 | (tw << 3));
			for (int i = 0; i < 4; i++) begin
				dat = 8'($urandom);
				sel = (i == 0) ? 8'h00 : 8'($urandom);
				apb(1'b1, 8'h04, {13'h0, 3'h7, sel, dat});
				apb(1'b1, 8'h04, {13'h0, 3'h7, 8'h00, ~dat});
				wait_idle();
				m = scan_model(sd, dat, sel);
				check(32'(scan_data), 32'(m[15:8]));
				check(32'(rdv[15:8]), 32'(m[7:0]));
				sd = m[15:8];
			end
		end
		// Back to joint format before scan goes off
		apb(1'b1, 8'h00, 32'h1);
		two_wire <= 1'b0;
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h04, 32'h7_00A5);
		repeat (60) @(posedge pclk);
		check(32'(scan_data), 32'(sd));
		check(32'(dbp_link_if_i.tck), 32'h1);
		tally_and_finish();
	end
endmodule : debug_probe_scan_and_gpio_port_tb
`default_nettype wire
